// *** src/pxd_pkg.sv ***
// Package of constants and types for the PCI to extended I/O decode block
package pxd_pkg;
  // Configuration offsets
  localparam logic [7:0] OFS_HEADER_TYPE = 8'h0e;
  localparam logic [7:0] OFS_PORT_FWD = 8'h49;
  localparam logic [7:0] OFS_RECOVERY = 8'h4c;
  localparam logic [7:0] OFS_ROM_DEC = 8'h4e;
  // Values after reset and write masks
  localparam logic [7:0] HEADER_TYPE_VAL = 8'h00;
  localparam logic [7:0] PORT_FWD_RST = 8'h00;
  localparam logic [7:0] RECOVERY_RST = 8'h48;
  localparam logic [7:0] ROM_DEC_RST = 8'h08;
  localparam logic [7:0] PORT_FWD_MASK = 8'h7f;
  localparam logic [7:0] RECOVERY_MASK = 8'h78;
  localparam logic [7:0] ROM_DEC_MASK = 8'hfc;
  // Field positions
  localparam int REC_EN_BIT = 6;
  localparam int REC_CODE_LSB = 3;
  localparam int ROM_EXT_BIT = 7;
  localparam int ROM_LOW1_BIT = 6;
  localparam int ROM_LOW0_DEC_BIT = 5;
  localparam int ROM_LOW0_CS_BIT = 4;
  localparam int ROM_FSEG_BIT = 3;
  localparam int ROM_WP_BIT = 2;
  // PCI commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // Timing: extended bus clock is the master clock divided by three
  localparam int EXTENDED_BUS_CLOCK_DIV = 3;
  localparam int BASE_GAP_HALF_EXTENDED_BUS_CLOCK = 7;
  localparam int BASE_GAP_CYC = (BASE_GAP_HALF_EXTENDED_BUS_CLOCK * EXTENDED_BUS_CLOCK_DIV + 1) / 2;
  localparam int STROBE_EXTENDED_BUS_CLOCK = 3;
  localparam int STROBE_CYC = STROBE_EXTENDED_BUS_CLOCK * EXTENDED_BUS_CLOCK_DIV;
  localparam int DEVSEL_DELAY_CYC = 2;
  localparam logic [1:0] DEVSEL_TIMING_MEDIUM = 2'h1;
  typedef logic [6:0] pxd_gap_t;

  // Extra extended bus clocks from the recovery register; 000 stands for 8
  function automatic logic [3:0] pxd_extra_extended_bus_clock(input logic [7:0] rec);
    logic [2:0] code;
    code = rec[REC_CODE_LSB +: 3];
    if (!rec[REC_EN_BIT]) begin
      return 4'h0;
    end
    return (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction : pxd_extra_extended_bus_clock

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range
endpackage : pxd_pkg

// *** src/pxd_decode.sv ***
// Claim and boot ROM select decoder for forwarded PCI cycles
`timescale 1ns/100ps
module pxd_decode (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_cmd,
  input wire logic [7:0] i_port_fwd,
  input wire logic [7:0] i_rom_dec,
  output logic o_claim,
  output logic o_rom_cs,
  output logic o_is_io
);
  import pxd_pkg::*;
  logic io_cmd;
  logic mem_cmd;
  logic mem_wr;
  logic third_parallel_port_hit;
  logic first_serial_port_hit;
  logic ext_hit;
  logic [7:0] port_hit;
  logic low0;
  logic low1;
  logic fseg;
  logic wr_ok;

  assign io_cmd = (i_cmd == CMD_IO_RD) || (i_cmd == CMD_IO_WR);
  assign mem_cmd = (i_cmd == CMD_MEM_RD) || (i_cmd == CMD_MEM_WR);
  assign mem_wr = (i_cmd == CMD_MEM_WR);
  assign third_parallel_port_hit = in_range(i_addr, 32'h0000_0278, 32'h0000_027f)
                 || in_range(i_addr, 32'h0000_0678, 32'h0000_067b);
  assign first_serial_port_hit = in_range(i_addr, 32'h0000_03f8, 32'h0000_03ff);
  assign port_hit[0] = first_serial_port_hit && i_port_fwd[0];
  assign port_hit[1] = in_range(i_addr, 32'h0000_02f8, 32'h0000_02ff) && i_port_fwd[1];
  assign port_hit[2] = in_range(i_addr, 32'h0000_03e8, 32'h0000_03ef) && i_port_fwd[2];
  assign port_hit[3] = in_range(i_addr, 32'h0000_02e8, 32'h0000_02ef) && i_port_fwd[3];
  assign port_hit[4] = (in_range(i_addr, 32'h0000_03bc, 32'h0000_03bf)
                     || in_range(i_addr, 32'h0000_07bc, 32'h0000_07bf)) && i_port_fwd[4];
  assign port_hit[5] = (in_range(i_addr, 32'h0000_0378, 32'h0000_037f)
                     || in_range(i_addr, 32'h0000_0778, 32'h0000_077b)) && i_port_fwd[5];
  assign port_hit[6] = third_parallel_port_hit && i_port_fwd[6];
  assign port_hit[7] = 1'b0;
  // Low regions also answer at their alias just under 4 GB
  assign ext_hit = in_range(i_addr, 32'hfffc_0000, 32'hfffd_ffff);
  assign low0 = in_range(i_addr, 32'h000e_0000, 32'h000e_3fff)
             || in_range(i_addr, 32'hfffe_0000, 32'hfffe_3fff);
  assign low1 = in_range(i_addr, 32'h000e_4000, 32'h000e_ffff)
             || in_range(i_addr, 32'hfffe_4000, 32'hfffe_ffff);
  assign fseg = in_range(i_addr, 32'h000f_0000, 32'h000f_ffff)
             || in_range(i_addr, 32'hffff_0000, 32'hffff_ffff);
  // Writes to ROM space are dropped unless write protect is lifted
  assign wr_ok = !mem_wr || i_rom_dec[ROM_WP_BIT];

  always_comb begin
    o_is_io = io_cmd;
    o_claim = 1'b0;
    o_rom_cs = 1'b0;
    if (io_cmd) begin
      o_claim = |port_hit;
    end else if (mem_cmd && wr_ok) begin
      o_claim = (ext_hit && i_rom_dec[ROM_EXT_BIT])
             || (low1 && i_rom_dec[ROM_LOW1_BIT])
             || (low0 && i_rom_dec[ROM_LOW0_DEC_BIT])
             || (fseg && i_rom_dec[ROM_FSEG_BIT]);
      o_rom_cs = (ext_hit && i_rom_dec[ROM_EXT_BIT])
              || (low1 && i_rom_dec[ROM_LOW1_BIT])
              || (low0 && i_rom_dec[ROM_LOW0_CS_BIT])
              || (fseg && i_rom_dec[ROM_FSEG_BIT]);
    end
  end

  chk_third_parallel_port_gated: assert property (@(posedge i_mclk) disable iff (i_rst)
    (io_cmd && third_parallel_port_hit && !i_port_fwd[6]) |-> !o_claim)
    else $error("third parallel window claimed while disabled");
  chk_first_serial_port_gated: assert property (@(posedge i_mclk) disable iff (i_rst)
    (io_cmd && first_serial_port_hit) |-> (o_claim == i_port_fwd[0]))
    else $error("first serial window claim mismatch");
  chk_write_protect: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mem_wr && !i_rom_dec[ROM_WP_BIT]) |-> !(o_claim || o_rom_cs))
    else $error("protected ROM write claimed");
  chk_ext_rom_sel: assert property (@(posedge i_mclk) disable iff (i_rst)
    ((i_cmd == CMD_MEM_RD) && ext_hit) |-> (o_rom_cs == i_rom_dec[ROM_EXT_BIT]))
    else $error("extended ROM select mismatch");
endmodule : pxd_decode

// *** src/pxd_recovery.sv ***
// Recovery gap timer between 8-bit I/O commands on the extended bus
`timescale 1ns/100ps
module pxd_recovery (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_end,
  input wire logic i_sub,
  input wire logic [7:0] i_recovery,
  output logic o_ready
);
  import pxd_pkg::*;
  pxd_gap_t gap_reg;
  pxd_gap_t gap_load;

  // Sub-cycles of one wide access get only the fixed gap
  assign gap_load = i_sub ? pxd_gap_t'(BASE_GAP_CYC)
                  : pxd_gap_t'(BASE_GAP_CYC) + pxd_gap_t'(pxd_extra_extended_bus_clock(i_recovery))
                  * pxd_gap_t'(EXTENDED_BUS_CLOCK_DIV);
  assign o_ready = (gap_reg == '0);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gap_reg <= '0;
    end else if (i_end) begin
      gap_reg <= gap_load;
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 7'h01;
    end
  end

  chk_gap_loaded: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_end && !i_sub) |=> (gap_reg == pxd_gap_t'(BASE_GAP_CYC)
      + pxd_gap_t'(pxd_extra_extended_bus_clock($past(i_recovery))) * pxd_gap_t'(EXTENDED_BUS_CLOCK_DIV)))
    else $error("recovery gap loaded wrong");
  chk_sub_gap: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_end && i_sub) |=> (gap_reg == pxd_gap_t'(BASE_GAP_CYC)))
    else $error("sub-cycle gap carries extra delay");
endmodule : pxd_recovery

// *** src/pxd_bridge.sv ***
// Decode, claim and recovery control of the PCI to extended I/O bridge
`timescale 1ns/100ps
module pxd_bridge (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_cyc_valid,
  input wire logic [31:0] i_cyc_addr,
  input wire logic [3:0] i_cyc_cmd,
  input wire logic [2:0] i_cyc_bytes,
  output logic o_devsel_n,
  output logic [1:0] o_devsel_timing,
  output logic o_busy,
  output logic o_done,
  output logic o_extended_bus_clock,
  output logic [31:0] o_ext_addr,
  output logic o_io_read_strobe_n,
  output logic o_io_write_strobe_n,
  output logic o_mem_read_strobe_n,
  output logic o_mem_write_strobe_n,
  output logic o_boot_rom_chip_select_n
);
  import pxd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_MED, ST_WAIT, ST_STROBE, ST_DONE} pxd_state_t;

  pxd_state_t state_reg;
  logic [7:0] port_fwd_reg;
  logic [7:0] recovery_reg;
  logic [7:0] rom_dec_reg;
  logic claim;
  logic rom_cs;
  logic is_io;
  logic io_cyc_reg;
  logic wr_cyc_reg;
  logic cs_cyc_reg;
  logic [2:0] left_reg;
  logic [3:0] strobe_cnt_reg;
  logic [1:0] div_reg;
  logic rec_ready;
  logic strobe_end;
  logic sub_next;
  logic [4:0] since_rise_reg;
  logic io_strobe_n;

  // Configuration writes; reserved and 16-bit recovery bits never store
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      port_fwd_reg <= PORT_FWD_RST;
      recovery_reg <= RECOVERY_RST;
      rom_dec_reg <= ROM_DEC_RST;
    end else if (i_cfg_wr) begin
      if (i_cfg_addr == OFS_PORT_FWD) begin
        port_fwd_reg <= i_cfg_wdata & PORT_FWD_MASK;
      end
      if (i_cfg_addr == OFS_RECOVERY) begin
        recovery_reg <= i_cfg_wdata & RECOVERY_MASK;
      end
      if (i_cfg_addr == OFS_ROM_DEC) begin
        rom_dec_reg <= i_cfg_wdata & ROM_DEC_MASK;
      end
    end
  end

  // Read data comes from a flop one cycle after the read
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        OFS_HEADER_TYPE: o_cfg_rdata <= HEADER_TYPE_VAL;
        OFS_PORT_FWD: o_cfg_rdata <= port_fwd_reg;
        OFS_RECOVERY: o_cfg_rdata <= recovery_reg;
        OFS_ROM_DEC: o_cfg_rdata <= rom_dec_reg;
        default: o_cfg_rdata <= 8'h00;
      endcase
    end
  end

  pxd_decode u_decode (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_addr(i_cyc_addr),
    .i_cmd(i_cyc_cmd),
    .i_port_fwd(port_fwd_reg),
    .i_rom_dec(rom_dec_reg),
    .o_claim(claim),
    .o_rom_cs(rom_cs),
    .o_is_io(is_io)
  );

  pxd_recovery u_recovery (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_end(strobe_end),
    .i_sub(sub_next),
    .i_recovery(recovery_reg),
    .o_ready(rec_ready)
  );

  // Free running extended bus clock; strobes are timed in master clocks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 2'h0;
      o_extended_bus_clock <= 1'b0;
    end else begin
      div_reg <= (div_reg == 2'(EXTENDED_BUS_CLOCK_DIV - 1)) ? 2'h0 : div_reg + 2'h1;
      o_extended_bus_clock <= (div_reg == 2'h0);
    end
  end

  assign strobe_end = (state_reg == ST_STROBE) && (strobe_cnt_reg == 4'h1) && io_cyc_reg;
  assign sub_next = (left_reg != 3'h1);
  assign o_busy = (state_reg != ST_IDLE);
  assign o_devsel_timing = DEVSEL_TIMING_MEDIUM;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      io_cyc_reg <= 1'b0;
      wr_cyc_reg <= 1'b0;
      cs_cyc_reg <= 1'b0;
      left_reg <= 3'h0;
      strobe_cnt_reg <= 4'h0;
      o_ext_addr <= 32'h0000_0000;
      o_devsel_n <= 1'b1;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          // Unclaimed cycles are left alone on PCI
          if (i_cyc_valid && claim) begin
            state_reg <= ST_MED;
            io_cyc_reg <= is_io;
            wr_cyc_reg <= i_cyc_cmd[0];
            cs_cyc_reg <= rom_cs;
            left_reg <= (i_cyc_bytes == 3'h0) ? 3'h1 : i_cyc_bytes;
            o_ext_addr <= i_cyc_addr;
          end
        end
        ST_MED: begin
          o_devsel_n <= 1'b0;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // Memory cycles are not subject to I/O recovery
          if (rec_ready || !io_cyc_reg) begin
            state_reg <= ST_STROBE;
            strobe_cnt_reg <= 4'(STROBE_CYC);
          end
        end
        ST_STROBE: begin
          strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
          if (strobe_cnt_reg == 4'h1) begin
            left_reg <= left_reg - 3'h1;
            if (left_reg == 3'h1) begin
              state_reg <= ST_DONE;
            end else begin
              state_reg <= ST_WAIT;
              o_ext_addr <= o_ext_addr + 32'h1;
            end
          end
        end
        ST_DONE: begin
          o_devsel_n <= 1'b1;
          o_done <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Strobes drive from flops so they stay glitch free on the bus
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_io_read_strobe_n <= 1'b1;
      o_io_write_strobe_n <= 1'b1;
      o_mem_read_strobe_n <= 1'b1;
      o_mem_write_strobe_n <= 1'b1;
      o_boot_rom_chip_select_n <= 1'b1;
    end else begin
      o_io_read_strobe_n <= 1'b1;
      o_io_write_strobe_n <= 1'b1;
      o_mem_read_strobe_n <= 1'b1;
      o_mem_write_strobe_n <= 1'b1;
      o_boot_rom_chip_select_n <= 1'b1;
      if ((state_reg == ST_WAIT && (rec_ready || !io_cyc_reg))
          || (state_reg == ST_STROBE && strobe_cnt_reg != 4'h1)) begin
        o_io_read_strobe_n <= !(io_cyc_reg && !wr_cyc_reg);
        o_io_write_strobe_n <= !(io_cyc_reg && wr_cyc_reg);
        o_mem_read_strobe_n <= !(!io_cyc_reg && !wr_cyc_reg);
        o_mem_write_strobe_n <= !(!io_cyc_reg && wr_cyc_reg);
        o_boot_rom_chip_select_n <= !cs_cyc_reg;
      end
    end
  end

  // Helper: master clocks since the last I/O command went inactive
  assign io_strobe_n = o_io_read_strobe_n && o_io_write_strobe_n;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      since_rise_reg <= 5'h1f;
    end else if (!io_strobe_n) begin
      since_rise_reg <= 5'h00;
    end else if (since_rise_reg != 5'h1f) begin
      since_rise_reg <= since_rise_reg + 5'h01;
    end
  end

  chk_header_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_cfg_rd && i_cfg_addr == OFS_HEADER_TYPE) |=> (o_cfg_rdata == 8'h00))
    else $error("header type not zero");
  chk_rec_low_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_cfg_rd && i_cfg_addr == OFS_RECOVERY) |=> (o_cfg_rdata[2:0] == 3'h0))
    else $error("16-bit recovery bits not zero");
  chk_devsel_medium: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_reg == ST_IDLE && i_cyc_valid && claim) |-> ##2 !o_devsel_n)
    else $error("device select not medium timing");
  chk_no_claim: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_reg == ST_IDLE && i_cyc_valid && !claim) |=> (state_reg == ST_IDLE))
    else $error("unclaimed cycle taken");
  chk_base_gap: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($fell(io_strobe_n) && since_rise_reg != 5'h1f)
      |-> (since_rise_reg >= 5'(BASE_GAP_CYC)))
    else $error("I/O recovery gap too short");
  chk_done_release: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_done |-> (o_devsel_n && state_reg == ST_IDLE))
    else $error("device select held after done");
endmodule : pxd_bridge

// *** test/pxd_pci_master.sv ***
// PCI master model issuing configuration and forwarded cycles to the bridge
`timescale 1ns/100ps
module pxd_pci_master (
  input wire logic i_mclk,
  output logic o_cfg_wr,
  output logic o_cfg_rd,
  output logic [7:0] o_cfg_addr,
  output logic [7:0] o_cfg_wdata,
  input wire logic [7:0] i_cfg_rdata,
  output logic o_cyc_valid,
  output logic [31:0] o_cyc_addr,
  output logic [3:0] o_cyc_cmd,
  output logic [2:0] o_cyc_bytes,
  input wire logic i_devsel_n,
  input wire logic i_done,
  input wire logic i_io_rd_n,
  input wire logic i_io_wr_n,
  input wire logic i_mem_rd_n,
  input wire logic i_mem_wr_n,
  input wire logic i_cs_n
);
  import pxd_pkg::*;
  initial begin
    o_cfg_wr = 1'b0;
    o_cfg_rd = 1'b0;
    o_cfg_addr = 8'h00;
    o_cfg_wdata = 8'h00;
    o_cyc_valid = 1'b0;
    o_cyc_addr = 32'h0;
    o_cyc_cmd = 4'h0;
    o_cyc_bytes = 3'h1;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_cfg_wr <= 1'b1;
    o_cfg_addr <= a;
    o_cfg_wdata <= d;
    @(posedge i_mclk);
    o_cfg_wr <= 1'b0;
    o_cfg_addr <= ~a;
    o_cfg_wdata <= ~d;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_cfg_rd <= 1'b1;
    o_cfg_addr <= a;
    @(posedge i_mclk);
    o_cfg_rd <= 1'b0;
    o_cfg_addr <= ~a;
    #1 d = i_cfg_rdata;
  endtask : cfg_read

  // Runs one address phase and counts what the bridge does until done or give-up
  task automatic run_cycle(input logic [3:0] c, input logic [31:0] a, input logic [2:0] n,
                           output int dly, output int ns, output int nb, output int nc,
                           output bit hung);
    logic [3:0] lo;
    int ix;
    dly = 0;
    ns = 0;
    nb = 0;
    nc = 0;
    ix = (c == CMD_IO_RD) ? 3 : (c == CMD_IO_WR) ? 2 : (c == CMD_MEM_RD) ? 1 : 0;
    @(posedge i_mclk);
    o_cyc_valid <= 1'b1;
    o_cyc_addr <= a;
    o_cyc_cmd <= c;
    o_cyc_bytes <= n;
    @(posedge i_mclk);
    o_cyc_valid <= 1'b0;
    o_cyc_addr <= ~a;
    o_cyc_cmd <= ~c;
    for (int k = 1; k < 250; k++) begin
      @(posedge i_mclk);
      #1;
      lo = ~{i_io_rd_n, i_io_wr_n, i_mem_rd_n, i_mem_wr_n};
      if (i_devsel_n === 1'b0 && dly == 0) begin
        dly = k;
      end
      ns += lo[ix];
      nb += $countones(lo) - lo[ix];
      nc += (i_cs_n === 1'b0);
      if (i_done === 1'b1 || (dly == 0 && k >= 20)) begin
        break;
      end
    end
    hung = (dly != 0 && i_done !== 1'b1);
  endtask : run_cycle
endmodule : pxd_pci_master

// *** test/pxd_bridge_tb.sv ***
// Self-checking bench for the PCI to extended I/O decode bridge
`timescale 1ns/100ps
module pxd_bridge_tb;
  import pxd_pkg::*;
  logic i_mclk;
  logic i_rst;
  logic cfg_wr, cfg_rd, cyc_valid, devsel_n, busy, done, xclk;
  logic io_rd_n, io_wr_n, mem_rd_n, mem_wr_n, cs_n;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [31:0] cyc_addr, ext_addr;
  logic [3:0] cyc_cmd;
  logic [2:0] cyc_bytes;
  logic [1:0] devsel_timing;
  int num_errors = 0;
  int n_compared = 0;
  int since = 0;
  int gaps[$];
  logic io_q = 1'b1;

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  pxd_bridge u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd),
    .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
    .i_cyc_valid(cyc_valid), .i_cyc_addr(cyc_addr), .i_cyc_cmd(cyc_cmd),
    .i_cyc_bytes(cyc_bytes), .o_devsel_n(devsel_n), .o_devsel_timing(devsel_timing),
    .o_busy(busy), .o_done(done), .o_extended_bus_clock(xclk), .o_ext_addr(ext_addr),
    .o_io_read_strobe_n(io_rd_n), .o_io_write_strobe_n(io_wr_n),
    .o_mem_read_strobe_n(mem_rd_n), .o_mem_write_strobe_n(mem_wr_n),
    .o_boot_rom_chip_select_n(cs_n));

  pxd_pci_master u_pci (.i_mclk(i_mclk), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd),
    .o_cfg_addr(cfg_addr), .o_cfg_wdata(cfg_wdata), .i_cfg_rdata(cfg_rdata),
    .o_cyc_valid(cyc_valid), .o_cyc_addr(cyc_addr), .o_cyc_cmd(cyc_cmd),
    .o_cyc_bytes(cyc_bytes), .i_devsel_n(devsel_n), .i_done(done), .i_io_rd_n(io_rd_n),
    .i_io_wr_n(io_wr_n), .i_mem_rd_n(mem_rd_n), .i_mem_wr_n(mem_wr_n), .i_cs_n(cs_n));

  // Cycles of I/O strobe high before each falling edge
  always @(posedge i_mclk) begin
    if (!(io_rd_n & io_wr_n) && io_q) begin
      gaps.push_back(since);
    end
    since = (io_rd_n & io_wr_n) ? since + 1 : 0;
    io_q = io_rd_n & io_wr_n;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic gap_chk(input int i, input int lo);
    int g;
    g = (gaps.size() > i) ? gaps[i] : -1;
    n_compared++;
    // Lower bound is the rule; two cycles of slack absorb launch alignment
    if (g < lo || g > lo + 2) begin
      num_errors++;
      $display("[FAIL] recovery gap expected %0d seen %0d", lo, g);
    end
  endtask : gap_chk

  task automatic cyc(input logic [3:0] c, input logic [31:0] a, input logic [2:0] n,
                     input bit claim, input bit cs);
    int dly, ns, nb, nc;
    bit hung;
    u_pci.run_cycle(c, a, n, dly, ns, nb, nc, hung);
    if (hung) begin
      num_errors++;
      $display("[FAIL] cycle done expected 1 seen 0");
      complete_run();
    end
    // Devsel is seen low one edge after the address edge, so sampled low on the first loop edge
    chk("devsel delay", claim ? 1 : 0, dly);
    chk("devsel timing", 2'h1, devsel_timing);
    chk("strobe cycles", claim ? 9 * n : 0, ns);
    chk("select cycles", (claim && cs) ? 9 * n : 0, nc);
    chk("stray strobes", 0, nb);
    chk("busy after cycle", 0, busy);
    if (claim) begin
      chk("last sub-cycle address", a + 32'(n) - 32'h1, ext_addr);
    end
  endtask : cyc

  task automatic test_regs();
    logic [7:0] ofs [5] = '{8'h0e, 8'h49, 8'h4c, 8'h4e, 8'h50};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h48, 8'h08, 8'h00};
    logic [7:0] mk [5] = '{8'h00, 8'h7f, 8'h78, 8'hfc, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      u_pci.cfg_read(ofs[i], d);
      chk("reset value", rv[i], d);
    end
    for (int i = 0; i < 5; i++) begin
      u_pci.cfg_write(ofs[i], 8'hff);
      u_pci.cfg_read(ofs[i], d);
      chk("written value", mk[i], d);
    end
    $display("test registers done");
  endtask : test_regs

  task automatic test_ports();
    int pb [14] = '{6, 6, 5, 5, 4, 4, 0, 0, 1, 1, 2, 2, 3, 3};
    logic [31:0] pa [14] = '{32'h278, 32'h67b, 32'h378, 32'h77b, 32'h3bc, 32'h7bf,
      32'h3f8, 32'h3ff, 32'h2f8, 32'h2ff, 32'h3e8, 32'h3ef, 32'h2e8, 32'h2ef};
    logic [7:0] m;
    u_pci.cfg_write(8'h4e, 8'h00);
    for (int i = 0; i < 14; i++) begin
      m = 8'h01 << pb[i];
      u_pci.cfg_write(8'h49, m);
      cyc(i[0] ? CMD_IO_WR : CMD_IO_RD, pa[i], 3'h1, 1'b1, 1'b0);
      u_pci.cfg_write(8'h49, ~m & 8'h7f);
      cyc(CMD_IO_RD, pa[i], 3'h1, 1'b0, 1'b0);
    end
    u_pci.cfg_write(8'h49, 8'h7f);
    cyc(CMD_IO_RD, 32'h280, 3'h1, 1'b0, 1'b0);
    cyc(CMD_MEM_RD, 32'h3f8, 3'h1, 1'b0, 1'b0);
    $display("test port windows done");
  endtask : test_ports

  task automatic test_recovery();
    int x;
    u_pci.cfg_write(8'h49, 8'h01);
    for (int i = 0; i < 9; i++) begin
      x = (i == 8) ? 0 : (i == 0) ? 8 : i;
      u_pci.cfg_write(8'h4c, (i == 8) ? 8'h00 : 8'h40 | 8'(i << 3));
      cyc(CMD_IO_WR, 32'h3f8, 3'h1, 1'b1, 1'b0);
      gaps.delete();
      cyc(CMD_IO_RD, 32'h3fb, 3'h1, 1'b1, 1'b0);
      gap_chk(0, 11 + 3 * x);
    end
    $display("test recovery done");
  endtask : test_recovery

  task automatic test_subcycles();
    u_pci.cfg_write(8'h4c, 8'h40);
    cyc(CMD_IO_WR, 32'h3f8, 3'h1, 1'b1, 1'b0);
    gaps.delete();
    cyc(CMD_IO_RD, 32'h3f8, 3'h4, 1'b1, 1'b0);
    chk("gap count", 4, gaps.size());
    gap_chk(0, 35);
    for (int i = 1; i < 4; i++) begin
      gap_chk(i, 11);
    end
    $display("test sub-cycles done");
  endtask : test_subcycles

  task automatic test_rom();
    logic [7:0] rv [13] = '{8'h80, 8'h84, 8'h80, 8'h00, 8'h40, 8'h40, 8'h00, 8'h20, 8'h10,
      8'h30, 8'h08, 8'h00, 8'h08};
    logic [31:0] ra [13] = '{32'hfffc0000, 32'hfffdffff, 32'hfffdffff, 32'hfffc0000,
      32'h0e4000, 32'hfffeffff, 32'h0effff, 32'h0e0000, 32'h0e3fff, 32'hfffe0000,
      32'h0f0000, 32'h0fffff, 32'h0f0000};
    logic [3:0] rc [13] = '{4'h6, 4'h7, 4'h7, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
      4'h6, 4'h6, 4'h2};
    bit cl [13] = '{1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 1, 0, 0};
    bit cs [13] = '{1, 1, 0, 0, 1, 1, 0, 0, 0, 1, 1, 0, 0};
    u_pci.cfg_write(8'h49, 8'h00);
    for (int i = 0; i < 13; i++) begin
      u_pci.cfg_write(8'h4e, rv[i]);
      cyc(rc[i], ra[i], 3'h1, cl[i], cs[i]);
    end
    $display("test boot ROM decode done");
  endtask : test_rom

  initial begin
    i_rst = 1'b1;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    test_regs();
    test_ports();
    test_recovery();
    test_subcycles();
    test_rom();
    complete_run();
  end

  // Cut a hung run short
  initial begin
    repeat (60000) @(posedge i_mclk);
    num_errors++;
    $display("[FAIL] run end expected finish seen timeout");
    complete_run();
  end
endmodule : pxd_bridge_tb
